// file: design/cw_power_test_pkg.sv
// Constants for the continuous-wave power-down and gain-stage test-control register bank.
// Assumes a single register clock, an active-low asynchronous reset and a plain strobe register port.
// Operation
// - Two eight-bit masks, one for the converters and one for the amplifier chains, power each channel down alone.
// - At reset values every channel's attenuator, gain amplifier and converter stay powered.
// - The test-enable bit, bit 9 of the test register, routes the gain outputs of channels 7 and 8 to the summing pins.
// - Bit 8 of the test register powers the buffer outside power-down, and the routed signals then show at its outputs, else at its inputs.
// - Bits 4 to 0 of the gain register select the buffer feedback, with 0x10 picking the internal 2K resistor.
// - Register contents survive partial and complete power-down, so no reprogramming is needed on wake-up.
`default_nettype none

package cw_power_test_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CH_N = 8;
  localparam int WORD_N = 4;
  localparam int IDX_W = 2;

  localparam logic [7:0] BUF_GAIN_OFF = 8'h36;
  localparam logic [7:0] TEST_CTRL_OFF = 8'h3B;
  localparam logic [7:0] CONV_MASK_OFF = 8'h40;
  localparam logic [7:0] AMP_MASK_OFF = 8'h41;

  localparam logic [1:0] BUF_GAIN_IDX = 2'h0;
  localparam logic [1:0] TEST_CTRL_IDX = 2'h1;
  localparam logic [1:0] CONV_MASK_IDX = 2'h2;
  localparam logic [1:0] AMP_MASK_IDX = 2'h3;

  localparam int TEST_EN_BIT = 9;
  localparam int BUF_ON_BIT = 8;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 5;
  localparam logic [4:0] GAIN_2K_FEEDBACK = 5'h10;

  localparam logic [15:0] BUF_GAIN_RST = 16'h0000;
  localparam logic [15:0] TEST_CTRL_RST = 16'h0000;
  localparam logic [15:0] CONV_MASK_RST = 16'h0000;
  localparam logic [15:0] AMP_MASK_RST = 16'h0000;

  localparam logic [15:0] FULL_WORD_MASK = 16'hFFFF;
  localparam logic [15:0] CH_MASK_BITS = 16'h00FF;

endpackage

`default_nettype wire

// file: design/cw_reg_store.sv
// Four-word register storage with a registered read port.
// Assumes the caller decodes addresses to word indices and supplies a per-word writable-bit mask.
`default_nettype none

module cw_reg_store (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_we,
  input wire logic [cw_power_test_pkg::IDX_W-1:0] i_widx,
  input wire logic [cw_power_test_pkg::DATA_W-1:0] i_wdata,
  input wire logic [cw_power_test_pkg::DATA_W-1:0] i_wmask,
  input wire logic i_re,
  input wire logic [cw_power_test_pkg::IDX_W-1:0] i_ridx,
  output logic [cw_power_test_pkg::DATA_W-1:0] o_rdata,
  output logic [cw_power_test_pkg::WORD_N*cw_power_test_pkg::DATA_W-1:0] o_words
);

  function automatic logic [cw_power_test_pkg::DATA_W-1:0] reset_word(input int idx);
    logic [cw_power_test_pkg::DATA_W-1:0] val;
    val = cw_power_test_pkg::BUF_GAIN_RST;
    if (idx == int'(cw_power_test_pkg::TEST_CTRL_IDX)) begin
      val = cw_power_test_pkg::TEST_CTRL_RST;
    end else if (idx == int'(cw_power_test_pkg::CONV_MASK_IDX)) begin
      val = cw_power_test_pkg::CONV_MASK_RST;
    end else if (idx == int'(cw_power_test_pkg::AMP_MASK_IDX)) begin
      val = cw_power_test_pkg::AMP_MASK_RST;
    end
    return val;
  endfunction

  genvar g;
  generate
    for (g = 0; g < cw_power_test_pkg::WORD_N; g++) begin : g_word
      localparam logic [cw_power_test_pkg::DATA_W-1:0] RST_VAL = reset_word(g);
      logic [cw_power_test_pkg::DATA_W-1:0] word_reg;
      // Only the reset and decoded writes change a word; the power-down inputs never reach the storage.
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          word_reg <= RST_VAL;
        end else if (i_we && (i_widx == cw_power_test_pkg::IDX_W'(g))) begin
          word_reg <= i_wdata & i_wmask;
        end
      end
      assign o_words[g*cw_power_test_pkg::DATA_W +: cw_power_test_pkg::DATA_W] = word_reg;
    end
  endgenerate

  // Read data stand for the one cycle after the strobe and are zero otherwise.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 16'h0000;
    end else if (i_re) begin
      o_rdata <= o_words[int'(i_ridx)*cw_power_test_pkg::DATA_W +: cw_power_test_pkg::DATA_W];
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

// file: design/cw_power_and_pga_test_control.sv
// Register bank for per-channel continuous-wave power-down and the gain-stage test routing.
// Assumes a master that holds strobes one cycle, never both at once, and reads data the cycle after a read strobe.
//
// Implementation choice: strobed register access.
`default_nettype none

module cw_power_and_pga_test_control (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [cw_power_test_pkg::ADDR_W-1:0] i_addr,
  input wire logic [cw_power_test_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_partial_pdn,
  input wire logic i_complete_pdn,
  output logic [cw_power_test_pkg::DATA_W-1:0] o_rdata,
  output logic [cw_power_test_pkg::CH_N-1:0] o_converter_channel_off_mask,
  output logic [cw_power_test_pkg::CH_N-1:0] o_amp_chain_channel_off_mask,
  output logic o_test_route_en,
  output logic o_buffer_on,
  output logic [cw_power_test_pkg::GAIN_W-1:0] o_buffer_gain,
  output logic o_route_to_summing_input_pins,
  output logic o_route_to_summing_output_pins
);

  typedef struct packed {
    logic hit;
    logic [cw_power_test_pkg::IDX_W-1:0] idx;
    logic [cw_power_test_pkg::DATA_W-1:0] wmask;
  } decode_t;

  // One decoder serves both the write and the read path, so the two can never disagree on the map.
  function automatic decode_t decode_addr(input logic [cw_power_test_pkg::ADDR_W-1:0] addr);
    decode_t d;
    d.hit = 1'b1;
    d.idx = cw_power_test_pkg::BUF_GAIN_IDX;
    d.wmask = cw_power_test_pkg::FULL_WORD_MASK;
    unique case (addr)
      cw_power_test_pkg::BUF_GAIN_OFF: begin
        d.idx = cw_power_test_pkg::BUF_GAIN_IDX;
      end
      cw_power_test_pkg::TEST_CTRL_OFF: begin
        d.idx = cw_power_test_pkg::TEST_CTRL_IDX;
      end
      cw_power_test_pkg::CONV_MASK_OFF: begin
        d.idx = cw_power_test_pkg::CONV_MASK_IDX;
        d.wmask = cw_power_test_pkg::CH_MASK_BITS;
      end
      cw_power_test_pkg::AMP_MASK_OFF: begin
        d.idx = cw_power_test_pkg::AMP_MASK_IDX;
        d.wmask = cw_power_test_pkg::CH_MASK_BITS;
      end
      default: begin
        d.hit = 1'b0;
      end
    endcase
    return d;
  endfunction

  decode_t dec;
  wire logic wr_hit;
  wire logic rd_hit;
  logic [cw_power_test_pkg::WORD_N*cw_power_test_pkg::DATA_W-1:0] words;

  assign dec = decode_addr(i_addr);
  assign wr_hit = i_wr && dec.hit;
  assign rd_hit = i_rd && dec.hit;

  // An unmapped read returns zero because the store only loads on a decoded hit.
  cw_reg_store u_store (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_we(wr_hit),
    .i_widx(dec.idx),
    .i_wdata(i_wdata),
    .i_wmask(dec.wmask),
    .i_re(rd_hit),
    .i_ridx(dec.idx),
    .o_rdata(o_rdata),
    .o_words(words)
  );

  wire logic [cw_power_test_pkg::DATA_W-1:0] gain_word;
  wire logic [cw_power_test_pkg::DATA_W-1:0] test_word;
  wire logic [cw_power_test_pkg::DATA_W-1:0] conv_word;
  wire logic [cw_power_test_pkg::DATA_W-1:0] amp_word;

  assign gain_word = words[int'(cw_power_test_pkg::BUF_GAIN_IDX)*cw_power_test_pkg::DATA_W +: cw_power_test_pkg::DATA_W];
  assign test_word = words[int'(cw_power_test_pkg::TEST_CTRL_IDX)*cw_power_test_pkg::DATA_W +: cw_power_test_pkg::DATA_W];
  assign conv_word = words[int'(cw_power_test_pkg::CONV_MASK_IDX)*cw_power_test_pkg::DATA_W +: cw_power_test_pkg::DATA_W];
  assign amp_word = words[int'(cw_power_test_pkg::AMP_MASK_IDX)*cw_power_test_pkg::DATA_W +: cw_power_test_pkg::DATA_W];

  // The power-down inputs only gate the outputs; they are ORed into both off masks and clear the buffer-on bit.
  wire logic any_pdn;
  wire logic test_en;
  wire logic buf_on;
  wire logic [cw_power_test_pkg::CH_N-1:0] conv_off_next;
  wire logic [cw_power_test_pkg::CH_N-1:0] amp_off_next;
  wire logic [cw_power_test_pkg::GAIN_W-1:0] gain_next;

  assign any_pdn = i_partial_pdn || i_complete_pdn;
  assign conv_off_next = conv_word[cw_power_test_pkg::CH_N-1:0] | {cw_power_test_pkg::CH_N{any_pdn}};
  assign amp_off_next = amp_word[cw_power_test_pkg::CH_N-1:0] | {cw_power_test_pkg::CH_N{any_pdn}};
  assign test_en = test_word[cw_power_test_pkg::TEST_EN_BIT];
  assign buf_on = test_word[cw_power_test_pkg::BUF_ON_BIT] && !any_pdn;
  assign gain_next = gain_word[cw_power_test_pkg::GAIN_LSB +: cw_power_test_pkg::GAIN_W];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_converter_channel_off_mask <= 8'h00;
      o_amp_chain_channel_off_mask <= 8'h00;
    end else begin
      o_converter_channel_off_mask <= conv_off_next;
      o_amp_chain_channel_off_mask <= amp_off_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_test_route_en <= 1'b0;
      o_buffer_on <= 1'b0;
      o_buffer_gain <= 5'h00;
    end else begin
      o_test_route_en <= test_en;
      o_buffer_on <= buf_on;
      o_buffer_gain <= gain_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_route_to_summing_input_pins <= 1'b0;
      o_route_to_summing_output_pins <= 1'b0;
    end else begin
      o_route_to_summing_input_pins <= test_en && !buf_on;
      o_route_to_summing_output_pins <= test_en && buf_on;
    end
  end

endmodule

`default_nettype wire

// file: tb/cw_power_checker.sv
// Concurrent checks on the ports of the power-down and test-control register bank.
// Assumes it is bound to the bank and sees only the bank's ports.
`default_nettype none
module cw_power_checker (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_partial_pdn,
  input wire logic i_complete_pdn,
  input wire logic [15:0] o_rdata,
  input wire logic [7:0] o_converter_channel_off_mask,
  input wire logic [7:0] o_amp_chain_channel_off_mask,
  input wire logic o_test_route_en,
  input wire logic o_buffer_on,
  input wire logic [4:0] o_buffer_gain,
  input wire logic o_route_to_summing_input_pins,
  input wire logic o_route_to_summing_output_pins
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // A write during power-down is stored but masked, so mask checks need it off for two edges.
  wire logic power_off = i_partial_pdn | i_complete_pdn;
  a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside its slot");
  a_conv_write: assert property (i_wr && i_addr == 8'h40 && !power_off ##1 !power_off |=>
    o_converter_channel_off_mask == $past(i_wdata[7:0], 2)) else $error("converter mask not applied");
  a_amp_write: assert property (i_wr && i_addr == 8'h41 && !power_off ##1 !power_off |=>
    o_amp_chain_channel_off_mask == $past(i_wdata[7:0], 2)) else $error("amplifier mask not applied");
  a_off_masks: assert property (power_off |=>
    o_converter_channel_off_mask == 8'hFF && o_amp_chain_channel_off_mask == 8'hFF) else $error("masks not forced");
  a_off_buffer: assert property (power_off |=> !o_buffer_on) else $error("buffer on in power-down");
  a_route_out: assert property (o_route_to_summing_output_pins == (o_test_route_en && o_buffer_on))
    else $error("output routing wrong");
  a_route_in: assert property (o_route_to_summing_input_pins == (o_test_route_en && !o_buffer_on))
    else $error("input routing wrong");
  a_gain_write: assert property (i_wr && i_addr == 8'h36 |-> ##2 o_buffer_gain == $past(i_wdata[4:0], 2))
    else $error("buffer gain not applied");
  a_test_write: assert property (i_wr && i_addr == 8'h3B |-> ##2 o_test_route_en == $past(i_wdata[9], 2))
    else $error("test enable not applied");
  cover property (power_off ##1 !power_off);
  cover property (o_route_to_summing_output_pins);
  cover property (o_route_to_summing_input_pins);
endmodule
bind cw_power_and_pga_test_control cw_power_checker u_chk (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_partial_pdn, .i_complete_pdn, .o_rdata, .o_converter_channel_off_mask, .o_amp_chain_channel_off_mask,
  .o_test_route_en, .o_buffer_on, .o_buffer_gain, .o_route_to_summing_input_pins, .o_route_to_summing_output_pins);
`default_nettype wire

// file: tb/test_cw_power_and_pga_test_control.sv
// Self-checking bench for the power-down and test-control register bank.
// Assumes reads answer one cycle after the strobe and control outputs follow one edge after storage.
`default_nettype none
module test_cw_power_and_pga_test_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_partial_pdn = 1'b0;
  logic i_complete_pdn = 1'b0;
  logic [15:0] o_rdata;
  logic [7:0] conv_off, amp_off;
  logic [4:0] gain;
  logic route_en, buf_on, to_in, to_out;
  wire logic [15:0] ctl = {3'h0, gain, 4'h0, route_en, buf_on, to_in, to_out};
  logic [7:0] addrs [4] = '{8'h36, 8'h3B, 8'h40, 8'h41};
  int bad_count = 0;
  int compares = 0;
  always #4 i_clk = ~i_clk;
  cw_power_and_pga_test_control uut (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .i_partial_pdn,
    .i_complete_pdn, .o_rdata, .o_converter_channel_off_mask(conv_off), .o_amp_chain_channel_off_mask(amp_off),
    .o_test_route_en(route_en), .o_buffer_on(buf_on), .o_buffer_gain(gain),
    .o_route_to_summing_input_pins(to_in), .o_route_to_summing_output_pins(to_out));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check(o_rdata, exp);
  endtask
  task automatic step;
    @(posedge i_clk);
    #1;
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    $display("ERROR at %0t: run did not finish", $time);
    bad_count++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    #1 check({conv_off, amp_off}, 16'h0000);
    check(ctl, 16'h0000);
    foreach (addrs[k]) rd(addrs[k], 16'h0000);
    for (int n = 0; n < 8; n++) begin
      wr(8'h40, 16'h0001 << n);
      wr(8'h41, 16'h0080 >> n);
      step();
      check({conv_off, amp_off}, {8'h01 << n, 8'h80 >> n});
    end
    wr(8'h40, 16'hFFA5);
    wr(8'h41, 16'h125A);
    rd(8'h40, 16'h00A5);
    rd(8'h41, 16'h005A);
    check({conv_off, amp_off}, 16'hA55A);
    wr(8'h36, 16'hABD0);
    rd(8'h36, 16'hABD0);
    // The unmapped write must leave the gain field alone, which the control word below shows.
    wr(8'h37, 16'h1234);
    rd(8'h37, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      wr(8'h3B, {6'h17, m[1:0], 8'h3C});
      rd(8'h3B, {6'h17, m[1:0], 8'h3C});
      check(ctl, {3'h0, 5'h10, 4'h0, m[1], m[0], m[1] & !m[0], m[1] & m[0]});
    end
    for (int p = 0; p < 2; p++) begin
      @(posedge i_clk);
      i_partial_pdn <= (p == 0);
      i_complete_pdn <= (p == 1);
      step();
      check({conv_off, amp_off}, 16'hFFFF);
      check(ctl, 16'h100A);
      rd(8'h40, 16'h00A5);
      @(posedge i_clk);
      i_partial_pdn <= 1'b0;
      i_complete_pdn <= 1'b0;
      step();
      check({conv_off, amp_off}, 16'hA55A);
      check(ctl, 16'h100D);
    end
    @(posedge i_clk);
    i_rstn <= 1'b0;
    step();
    check({conv_off, amp_off}, 16'h0000);
    check(ctl, 16'h0000);
    check(o_rdata, 16'h0000);
    i_rstn <= 1'b1;
    rd(8'h3B, 16'h0000);
    rd(8'h40, 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
